// >>> core/ioexp_top.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Eight port pins, each set to input or output by its own direction bit.
// - After power-up every pin is an input before any bus access.
// - Input register shows sampled pin levels; output register values stay latched.
// - A set polarity bit reports the inverted pin level, a clear bit reports it as is.
// - Power-on reset defaults all registers and idles the bus slave.
// - A low reset pin does the same defaulting as power-on reset.
// - The open-drain interrupt goes low while any input pin differs from its held value.
// - One select pin chooses between two slave addresses.
// - The slave works with bus clocks up to 400 kHz.
// - Address bit 1 is the select pin and bit 0 is one for read, zero for write.
// - After the address the command byte is stored in the pointer; 00h input, 01h output.
module ioexp_top (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial bus, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Address select strap
  input wire logic addr_sel,
  // Port pins, bit 0 is port_pin_zero, bit 7 is port_pin_seven
  input wire logic [7:0] port_in,
  output logic [7:0] port_out,
  output logic [7:0] port_oe_n,
  // Interrupt, open drain, active low
  output logic int_out,
  output logic int_oe_n
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [ioexp_pkg::SYN_W-1:0] syn;
  logic scl_s, sda_s, asel_s;
  logic [7:0] pin_s;

  // Bus lines, strap and pins all arrive from outside the clock domain
  ioexp_sync #(.W(ioexp_pkg::SYN_W), .INIT('1)) u_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .async_in({port_in, addr_sel, sda_in, scl_in}),
    .sync_out(syn)
  );

  assign scl_s = syn[ioexp_pkg::SYN_SCL];
  assign sda_s = syn[ioexp_pkg::SYN_SDA];
  assign asel_s = syn[ioexp_pkg::SYN_ASEL];
  assign pin_s = syn[ioexp_pkg::SYN_PORT +: 8];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
  } ioexp_state_t;

  ioexp_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic [7:0] out_r, out_nxt;
  logic [7:0] pol_r, pol_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] snap_r, snap_nxt;
  logic rw_r, rw_nxt;
  logic nack_r, nack_nxt;
  logic init_r, init_nxt;
  logic sda_oe_n_r, sda_oe_n_nxt;
  logic int_oe_n_r, int_oe_n_nxt;
  logic scl_d_r, sda_d_r;

  // Bus events seen on the filtered lines
  logic scl_rise, scl_fall, start_ev, stop_ev, byte_done, addr_hit;
  logic [7:0] rd_val;

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_ev = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign byte_done = (cnt_r == ioexp_pkg::BYTE_BITS);
  assign addr_hit = (sh_r[7:1] == {ioexp_pkg::ADDR_FIXED, asel_s});

  // Read mux, input register shows pins through polarity inversion
  always_comb begin
    if (ptr_r == ioexp_pkg::CMD_INPUT) begin
      rd_val = pin_s ^ pol_r;
    end else if (ptr_r == ioexp_pkg::CMD_OUTPUT) begin
      rd_val = out_r;
    end else if (ptr_r == ioexp_pkg::CMD_POLARITY) begin
      rd_val = pol_r;
    end else if (ptr_r == ioexp_pkg::CMD_CONFIG) begin
      rd_val = cfg_r;
    end else begin
      rd_val = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Slave state machine and register file, next values
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    out_nxt = out_r;
    pol_nxt = pol_r;
    cfg_nxt = cfg_r;
    snap_nxt = snap_r;
    rw_nxt = rw_r;
    nack_nxt = nack_r;
    init_nxt = 1'b0;
    sda_oe_n_nxt = sda_oe_n_r;
    // First clock after reset takes the held input values
    if (init_r) begin
      snap_nxt = pin_s;
    end
    // Sample incoming bits on the rising clock edge
    if (scl_rise) begin
      if (state_r == ST_RACK) begin
        nack_nxt = sda_s;
      end else if (state_r != ST_IDLE && !byte_done) begin
        sh_nxt = {sh_r[6:0], sda_s};
        cnt_nxt = cnt_r + 4'h1;
      end
    end
    if (start_ev) begin
      // Start or repeated start, listen for an address
      state_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      sda_oe_n_nxt = 1'b1;
    end else if (stop_ev) begin
      state_nxt = ST_IDLE;
      sda_oe_n_nxt = 1'b1;
    end else if (scl_fall) begin
      // Change the data line only while the clock is low
      case (state_r)
        ST_ADDR: begin
          if (byte_done) begin
            if (addr_hit) begin
              rw_nxt = sh_r[0];
              sda_oe_n_nxt = 1'b0;
              state_nxt = ST_ADDR_ACK;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          cnt_nxt = 4'h0;
          if (rw_r) begin
            tx_nxt = rd_val;
            sda_oe_n_nxt = rd_val[7];
            state_nxt = ST_RDATA;
            if (ptr_r == ioexp_pkg::CMD_INPUT) begin
              snap_nxt = pin_s;
            end
          end else begin
            sda_oe_n_nxt = 1'b1;
            state_nxt = ST_CMD;
          end
        end
        ST_CMD: begin
          if (byte_done) begin
            ptr_nxt = sh_r;
            sda_oe_n_nxt = 1'b0;
            state_nxt = ST_CMD_ACK;
          end
        end
        ST_CMD_ACK, ST_WACK: begin
          cnt_nxt = 4'h0;
          sda_oe_n_nxt = 1'b1;
          state_nxt = ST_WDATA;
        end
        ST_WDATA: begin
          if (byte_done) begin
            if (ptr_r == ioexp_pkg::CMD_OUTPUT) begin
              out_nxt = sh_r;
            end else if (ptr_r == ioexp_pkg::CMD_POLARITY) begin
              pol_nxt = sh_r;
            end else if (ptr_r == ioexp_pkg::CMD_CONFIG) begin
              cfg_nxt = sh_r;
            end
            sda_oe_n_nxt = 1'b0;
            state_nxt = ST_WACK;
          end
        end
        ST_RDATA: begin
          if (byte_done) begin
            sda_oe_n_nxt = 1'b1;
            state_nxt = ST_RACK;
          end else begin
            tx_nxt = {tx_r[6:0], 1'b0};
            sda_oe_n_nxt = tx_r[6];
          end
        end
        ST_RACK: begin
          cnt_nxt = 4'h0;
          if (nack_r) begin
            sda_oe_n_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end else begin
            tx_nxt = rd_val;
            sda_oe_n_nxt = rd_val[7];
            state_nxt = ST_RDATA;
            if (ptr_r == ioexp_pkg::CMD_INPUT) begin
              snap_nxt = pin_s;
            end
          end
        end
        default: begin
          sda_oe_n_nxt = 1'b1;
        end
      endcase
    end
  end

  // Interrupt compares input pins against held values, quiet while reference loads
  always_comb begin
    int_oe_n_nxt = init_r || ((pin_s & cfg_r) == (snap_r & cfg_r));
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Async reset covers power-on and the reset pin alike
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= ioexp_pkg::RST_POINTER;
      out_r <= ioexp_pkg::RST_OUTPUT;
      pol_r <= ioexp_pkg::RST_POLARITY;
      cfg_r <= ioexp_pkg::RST_CONFIG;
      snap_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b1;
      init_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      int_oe_n_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      sda_out <= 1'b0;
      int_out <= 1'b0;
      port_out <= ioexp_pkg::RST_OUTPUT;
      port_oe_n <= ioexp_pkg::RST_CONFIG;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      out_r <= out_nxt;
      pol_r <= pol_nxt;
      cfg_r <= cfg_nxt;
      snap_r <= snap_nxt;
      rw_r <= rw_nxt;
      nack_r <= nack_nxt;
      init_r <= init_nxt;
      sda_oe_n_r <= sda_oe_n_nxt;
      int_oe_n_r <= int_oe_n_nxt;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      sda_out <= 1'b0;
      int_out <= 1'b0;
      port_out <= out_nxt;
      port_oe_n <= cfg_nxt;
    end
  end

  assign sda_oe_n = sda_oe_n_r;
  assign int_oe_n = int_oe_n_r;
endmodule // ioexp_top
`default_nettype wire

// >>> pkg/ioexp_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// Shared constants of the eight-bit expander
// ----------------------------------------------------------------
package ioexp_pkg;
  // Port width
  localparam int PORT_W = 8;
  // Fixed upper six bits of the 7-bit slave address; bit 0 is the select pin
  localparam logic [5:0] ADDR_FIXED = 6'h10;
  // Command byte codes
  localparam logic [7:0] CMD_INPUT = 8'h00;
  localparam logic [7:0] CMD_OUTPUT = 8'h01;
  localparam logic [7:0] CMD_POLARITY = 8'h02;
  localparam logic [7:0] CMD_CONFIG = 8'h03;
  // Reset values
  localparam logic [7:0] RST_OUTPUT = 8'hFF;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'hFF;
  localparam logic [7:0] RST_POINTER = 8'h00;
  // Bits per byte on the serial bus, as a counter value
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Synchroniser input field positions
  localparam int SYN_SCL = 0;
  localparam int SYN_SDA = 1;
  localparam int SYN_ASEL = 2;
  localparam int SYN_PORT = 3;
  localparam int SYN_W = 11;
endpackage
`default_nettype wire

// >>> core/ioexp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Three-flop synchroniser with agreement filter
// ----------------------------------------------------------------
module ioexp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous input and filtered result
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_r, s2_r, s3_r, out_r;
  logic [W-1:0] out_nxt;

  // A bit changes only once stages two and three agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : out_r[i];
    end
  end

  // Stage registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      out_r <= INIT;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_out = out_r;
endmodule // ioexp_sync
`default_nettype wire

// >>> tb/ioexp_master.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// Serial bus master model
// --------
module ioexp_master (
  // Clock
  input wire logic core_clk,
  // Bus wires
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  // Bus idle, both wires released
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // Wait whole core cycles
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One bus clock of 160 ns, data moves only while clock is low
  task automatic bt(input logic b, output logic r);
    sda_m <= b;
    w(10);
    scl <= 1'b1;
    w(10);
    r = sda;
    w(10);
    scl <= 1'b0;
    w(10);
  endtask
  // Start or repeated start
  task automatic st();
    sda_m <= 1'b1;
    w(10);
    scl <= 1'b1;
    w(10);
    sda_m <= 1'b0;
    w(10);
    scl <= 1'b0;
    w(10);
  endtask
  // Stop, bus left idle
  task automatic sp();
    sda_m <= 1'b0;
    w(10);
    scl <= 1'b1;
    w(10);
    sda_m <= 1'b1;
    w(10);
  endtask
  // Byte out MSB first, reports acknowledge
  task automatic bo(input logic [7:0] d, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) bt(d[i], r);
    bt(1'b1, r);
    ak = !r;
  endtask
  // Byte in, ended by a not-acknowledge
  task automatic bi(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bt(1'b1, r);
      d[i] = r;
    end
    bt(1'b1, r);
  endtask
  // Register write: address with write bit, command, data
  task automatic wr(input logic [6:0] a, input logic [7:0] c, d, output logic ok);
    logic k0, k1, k2;
    st();
    bo({a, 1'b0}, k0);
    bo(c, k1);
    bo(d, k2);
    sp();
    ok = k0 & k1 & k2;
  endtask
  // Register read through a repeated start
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] d);
    logic k0, k1;
    st();
    bo({a, 1'b0}, k0);
    bo(c, k0);
    st();
    bo({a, 1'b1}, k1);
    bi(d);
    sp();
  endtask
endmodule // ioexp_master
`default_nettype wire

// >>> tb/ioexp_props.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// Port checker
// --------
module ioexp_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Strap, port and interrupt
  input wire logic addr_sel,
  input wire logic [7:0] port_in,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_oe_n,
  input wire logic int_out,
  input wire logic int_oe_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic [7:0] pm_r, pm_nxt;
  logic [3:0] q_r, q_nxt;
  // Cycles since a watched input pin moved
  always_comb begin
    pm_nxt = port_in & port_oe_n;
    q_nxt = (pm_nxt != pm_r) ? 4'h0 : q_r + {3'h0, q_r != 4'hF};
  end
  // Counter registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pm_r <= 8'hFF;
      q_r <= 4'h0;
    end else begin
      pm_r <= pm_nxt;
      q_r <= q_nxt;
    end
  end
  // Properties
  property p_rst_dir;
    $rose(rst_n) |-> (port_oe_n == 8'hFF && int_oe_n && sda_oe_n) ##1 int_oe_n;
  endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("pins not inputs");
  property p_rst_reg;
    $rose(rst_n) |-> port_out == 8'hFF;
  endproperty
  a_rst_reg: assert property (p_rst_reg) else $error("output not default");
  property p_od;
    sda_out == 1'b0 && int_out == 1'b0;
  endproperty
  a_od: assert property (p_od) else $error("open drain drives high");
  property p_dir_chg;
    !$stable(port_oe_n) |-> !scl_in;
  endproperty
  a_dir_chg: assert property (p_dir_chg) else $error("direction moved");
  property p_out_chg;
    !$stable(port_out) |-> !scl_in;
  endproperty
  a_out_chg: assert property (p_out_chg) else $error("output moved");
  property p_pull;
    $fell(sda_oe_n) |-> !scl_in;
  endproperty
  a_pull: assert property (p_pull) else $error("data pulled in clock high");
  property p_hold;
    $fell(sda_oe_n) |=> !sda_oe_n [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("data not held");
  property p_int_cause;
    $fell(int_oe_n) |-> q_r <= 4'hC;
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt without pin");
  // Main scenarios reached
  c_ack: cover property ($fell(sda_oe_n));
  c_int: cover property ($fell(int_oe_n));
  c_out: cover property (!$stable(port_out));
endmodule // ioexp_props
bind ioexp_top ioexp_props u_props (
  .core_clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe_n,
  .addr_sel, .port_in, .port_out, .port_oe_n, .int_out, .int_oe_n
);
`default_nettype wire

// >>> tb/i2c_eight_bit_io_expander_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
  samples_checked++; \
  if ((a) !== (e)) begin \
    bad_count++; \
    $display("Error at %0t: got %h want %h", $time, a, e); \
  end \
end
module i2c_eight_bit_io_expander_tb;
  localparam logic [6:0] A0 = {ioexp_pkg::ADDR_FIXED, 1'b0};
  localparam logic [6:0] A1 = {ioexp_pkg::ADDR_FIXED, 1'b1};
  logic core_clk;
  logic rst_n;
  logic addr_sel;
  logic [7:0] pins;
  logic scl, sda_m, sda_out, sda_oe_n, int_out, int_oe_n, ok;
  logic [7:0] port_out, port_oe_n, rv;
  wire logic sda, int_w;
  wire logic [7:0] port_w;
  int bad_count;
  int samples_checked;
  // Wires with pull-ups
  assign sda = sda_m & (sda_oe_n | sda_out);
  assign int_w = int_oe_n | int_out;
  assign port_w = (pins & port_oe_n) | (port_out & ~port_oe_n);
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  ioexp_top u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_sel(addr_sel),
    .port_in(port_w), .port_out(port_out), .port_oe_n(port_oe_n),
    .int_out(int_out), .int_oe_n(int_oe_n)
  );
  ioexp_master u_m (.core_clk(core_clk), .scl(scl), .sda_m(sda_m), .sda(sda));
  // Verdict and end of run
  task automatic report_and_stop();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Defaults after reset
  task automatic t_defaults();
    `CHK(port_oe_n, 8'hFF)
    `CHK(port_out, 8'hFF)
    u_m.rd(A0, ioexp_pkg::CMD_POLARITY, rv);
    `CHK(rv, 8'h00)
  endtask
  // Latched outputs driven on selected pins
  task automatic t_out();
    u_m.wr(A0, ioexp_pkg::CMD_OUTPUT, 8'h55, ok);
    `CHK(ok, 1'b1)
    `CHK(port_oe_n, 8'hFF)
    u_m.wr(A0, ioexp_pkg::CMD_CONFIG, 8'hF0, ok);
    `CHK(port_oe_n, 8'hF0)
    `CHK(port_w & 8'h0F, 8'h05)
    u_m.rd(A0, ioexp_pkg::CMD_OUTPUT, rv);
    `CHK(rv, 8'h55)
  endtask
  // Input register with and without inversion
  task automatic t_pol();
    pins <= 8'hA0;
    u_m.wr(A0, ioexp_pkg::CMD_POLARITY, 8'h30, ok);
    u_m.rd(A0, ioexp_pkg::CMD_INPUT, rv);
    `CHK(rv, 8'h95)
    u_m.wr(A0, ioexp_pkg::CMD_POLARITY, 8'h00, ok);
    u_m.rd(A0, ioexp_pkg::CMD_INPUT, rv);
    `CHK(rv, 8'hA5)
    `CHK(int_w, 1'b1)
  endtask
  // Interrupt raised, released by pin return and by read
  task automatic t_int();
    pins <= 8'h20;
    u_m.w(12);
    `CHK(int_w, 1'b0)
    pins <= 8'hA0;
    u_m.w(12);
    `CHK(int_w, 1'b1)
    pins <= 8'h2F;
    u_m.w(12);
    `CHK(int_w, 1'b0)
    u_m.rd(A0, ioexp_pkg::CMD_INPUT, rv);
    `CHK(rv, 8'h25)
    `CHK(int_w, 1'b1)
  endtask
  // Select pin moves the slave address
  task automatic t_addr();
    addr_sel <= 1'b1;
    u_m.w(10);
    u_m.wr(A0, ioexp_pkg::CMD_OUTPUT, 8'h00, ok);
    `CHK(ok, 1'b0)
    `CHK(port_out, 8'h55)
    u_m.wr(A1, ioexp_pkg::CMD_OUTPUT, 8'h3C, ok);
    `CHK(ok, 1'b1)
    `CHK(port_out, 8'h3C)
  endtask
  // Reset pin in mid-run
  task automatic t_rst();
    rst_n <= 1'b0;
    u_m.w(2);
    `CHK(port_oe_n, 8'hFF)
    `CHK(port_out, 8'hFF)
    rst_n <= 1'b1;
    u_m.w(8);
    u_m.rd(A1, ioexp_pkg::CMD_CONFIG, rv);
    `CHK(rv, 8'hFF)
  endtask
  // Main sequence
  initial begin
    rst_n <= 1'b0;
    addr_sel <= 1'b0;
    pins <= 8'hFF;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    u_m.w(8);
    t_defaults();
    t_out();
    t_pol();
    t_int();
    t_addr();
    t_rst();
    report_and_stop();
  end
  // Watchdog, about two and a half times the length of all scenarios
  initial begin
    #160000;
    bad_count++;
    report_and_stop();
  end
endmodule // i2c_eight_bit_io_expander_tb
`default_nettype wire
